/* File: design/csnap_pkg.sv */
// Constants, register map and helper functions for the conversion result snapshot block.
package csnap_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CEIL      = 6'h01;
  localparam logic [5:0] IDX_FLOOR     = 6'h02;
  localparam logic [5:0] IDX_CFG       = 6'h04;
  localparam logic [5:0] IDX_PWR       = 6'h0b;
  localparam logic [5:0] IDX_STATUS    = 6'h20;
  localparam logic [5:0] IDX_PROX_LO   = 6'h21;
  localparam logic [5:0] IDX_PROX_HI   = 6'h22;
  localparam logic [5:0] IDX_FREQ_LO   = 6'h23;
  localparam logic [5:0] IDX_FREQ_MID  = 6'h24;
  localparam logic [5:0] IDX_FREQ_HI   = 6'h25;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h31;

  // Field positions
  localparam int RESP_LSB       = 0;
  localparam int RESP_W         = 3;
  localparam int PWR_ACTIVE_BIT = 0;
  localparam int STAT_DRDY_BIT  = 6;
  localparam int STAT_OSC_BIT   = 7;
  localparam int IRQ_NEW_BIT    = 0;
  localparam int IRQ_OVR_BIT    = 1;
  localparam int IRQ_CLIP_BIT   = 2;
  localparam int IRQ_W          = 3;

  // Reset values
  localparam logic [7:0] FLOOR_RST = 8'h14;
  localparam logic [7:0] CEIL_RST  = 8'h00;
  localparam logic [2:0] RESP_RST  = 3'h0;
  localparam logic [2:0] MASK_RST  = 3'h0;

  // Timing
  localparam int CLK_MHZ         = 20;
  localparam int RESP_BASE       = 192;
  localparam int RESP_DIVISOR    = 3;
  localparam int OSC_TIMEOUT_NS  = 10000;
  localparam logic [7:0] OSC_TIMEOUT_CYC = 8'((OSC_TIMEOUT_NS * CLK_MHZ + 999) / 1000);

  // Sensor periods per conversion: one third of the response time
  function automatic logic [15:0] resp_periods(input logic [2:0] code);
    logic [15:0] base;
    base = 16'(RESP_BASE / RESP_DIVISOR);
    resp_periods = base << code;
  endfunction

  // Impedance code to comparison level on the 16-bit measurement scale
  function automatic logic [15:0] code_level(input logic [7:0] code);
    code_level = {code, 8'h00};
  endfunction

endpackage : csnap_pkg

/* File: design/csnap_conv_timer.sv */
// Conversion timer: sensor edge counting, frequency counter and oscillator watchdog.
module csnap_conv_timer
  import csnap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        osc_in,
  input  wire logic        enable,
  input  wire logic [2:0]  resp_code,
  output logic             conv_done,
  output logic [23:0]      freq_count,
  output logic             osc_stopped
);

  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic [15:0] edges;
    logic [23:0] ref_cnt;
    logic [23:0] result;
    logic        done;
    logic [7:0]  idle;
    logic        stopped;
  } csnap_tmr_s;

  csnap_tmr_s r_reg;
  csnap_tmr_s r_next;

  always_comb begin
    logic rise;
    rise = 1'b0;
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.sync = {r_reg.sync[1:0], osc_in};
    // Level accepted only once the two late stages agree; first stage feeds only the second
    if (r_reg.sync[1] == r_reg.sync[2] && r_reg.sync[2] != r_reg.lvl) begin
      r_next.lvl = r_reg.sync[2];
      rise = r_reg.sync[2];
    end
    if (!enable) begin
      r_next.edges = 16'h0000;
      r_next.ref_cnt = 24'h000000;
      r_next.idle = 8'h00;
      r_next.stopped = 1'b0;
    end else begin
      // Saturate so a stalled sensor never wraps to a small, plausible count
      if (r_reg.ref_cnt != 24'hffffff) begin
        r_next.ref_cnt = r_reg.ref_cnt + 24'h000001;
      end
      if (rise) begin
        r_next.idle = 8'h00;
        r_next.stopped = 1'b0;
        if (r_reg.edges + 16'h0001 >= resp_periods(resp_code)) begin
          r_next.result = r_next.ref_cnt;
          r_next.ref_cnt = 24'h000000;
          r_next.edges = 16'h0000;
          r_next.done = 1'b1;
        end else begin
          r_next.edges = r_reg.edges + 16'h0001;
        end
      end else if (r_reg.idle != OSC_TIMEOUT_CYC) begin
        r_next.idle = r_reg.idle + 8'h01;
      end else begin
        r_next.stopped = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign conv_done   = r_reg.done;
  assign freq_count  = r_reg.result;
  assign osc_stopped = r_reg.stopped;

endmodule // csnap_conv_timer

/* File: design/csnap_top.sv */
// APB register file and result snapshot logic of the inductive-sensing converter.
module csnap_top
  import csnap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_in,
  input  wire logic [15:0] rp_level,
  output logic             irq
);

  typedef struct packed {
    logic [2:0]  resp;
    logic        active;
    logic [7:0]  floor_code;
    logic [7:0]  ceil_code;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_stat;
    logic        pend;
    logic [15:0] lat_prox;
    logic [23:0] lat_freq;
    logic [15:0] snap_prox;
    logic [23:0] snap_freq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } csnap_top_s;

  csnap_top_s r_reg;
  csnap_top_s r_next;

  logic        conv_done;
  logic [23:0] freq_count;
  logic        osc_stopped;

  csnap_conv_timer u_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .osc_in      (osc_in),
    .enable      (r_reg.active),
    .resp_code   (r_reg.resp),
    .conv_done   (conv_done),
    .freq_count  (freq_count),
    .osc_stopped (osc_stopped)
  );

  function automatic logic is_mapped(input logic [5:0] idx);
    case (idx)
      IDX_CEIL, IDX_FLOOR, IDX_CFG, IDX_PWR, IDX_STATUS,
      IDX_PROX_LO, IDX_PROX_HI, IDX_FREQ_LO, IDX_FREQ_MID, IDX_FREQ_HI,
      IDX_IRQ_STAT, IDX_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [5:0]  idx;
    logic        setup;
    logic        wr;
    logic        rd_done;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    logic [15:0] clipped;
    logic        clip_evt;
    logic [2:0]  evt;
    logic [7:0]  rbyte;
    idx      = paddr[7:2];
    setup    = psel && !penable;
    wr       = psel && penable && r_reg.pready && pwrite;
    rd_done  = psel && penable && r_reg.pready && !pwrite;
    lo_lim   = code_level(r_reg.floor_code);
    hi_lim   = code_level(r_reg.ceil_code);
    clipped  = rp_level;
    clip_evt = 1'b0;
    evt      = 3'h0;
    rbyte    = 8'h00;
    r_next   = r_reg;

    // Measurement held inside the programmed window
    if (rp_level < lo_lim) begin
      clipped  = lo_lim;
      clip_evt = 1'b1;
    end else if (rp_level > hi_lim) begin
      clipped  = hi_lim;
      clip_evt = 1'b1;
    end

    // Finished conversions wait in a holding stage, invisible to software
    if (conv_done) begin
      r_next.lat_prox = clipped;
      r_next.lat_freq = freq_count;
      r_next.pend     = 1'b1;
      evt[IRQ_NEW_BIT]  = 1'b1;
      evt[IRQ_OVR_BIT]  = r_reg.pend;
      evt[IRQ_CLIP_BIT] = clip_evt;
    end

    // Only the start of a low-proximity read moves data into the visible set
    if (setup && !pwrite && idx == IDX_PROX_LO && r_next.pend) begin
      r_next.snap_prox = r_next.lat_prox;
      r_next.snap_freq = r_next.lat_freq;
      r_next.pend      = 1'b0;
    end

    // Register writes take effect at the access edge
    if (wr) begin
      case (idx)
        IDX_CEIL:     r_next.ceil_code  = pwdata[7:0];
        IDX_FLOOR:    r_next.floor_code = pwdata[7:0];
        IDX_CFG:      r_next.resp       = pwdata[RESP_LSB +: RESP_W];
        IDX_PWR:      r_next.active     = pwdata[PWR_ACTIVE_BIT];
        IDX_IRQ_MASK: r_next.irq_mask   = pwdata[IRQ_W-1:0];
        default:      r_next.active     = r_next.active;
      endcase
    end

    // Read clears the sticky status, but an event in the same cycle survives
    if (rd_done && idx == IDX_IRQ_STAT) begin
      r_next.irq_stat = evt;
    end else begin
      r_next.irq_stat = r_reg.irq_stat | evt;
    end

    // Read data formed in the setup cycle so it comes from a flip-flop
    case (idx)
      IDX_CEIL:     rbyte = r_next.ceil_code;
      IDX_FLOOR:    rbyte = r_next.floor_code;
      IDX_CFG:      rbyte = {5'h00, r_next.resp};
      IDX_PWR:      rbyte = {7'h00, r_next.active};
      IDX_STATUS: begin
        rbyte = 8'h00;
        rbyte[STAT_DRDY_BIT] = !r_next.pend;
        rbyte[STAT_OSC_BIT]  = osc_stopped;
      end
      IDX_PROX_LO:  rbyte = r_next.snap_prox[7:0];
      IDX_PROX_HI:  rbyte = r_next.snap_prox[15:8];
      IDX_FREQ_LO:  rbyte = r_next.snap_freq[7:0];
      IDX_FREQ_MID: rbyte = r_next.snap_freq[15:8];
      IDX_FREQ_HI:  rbyte = r_next.snap_freq[23:16];
      // Includes an event landing in the setup cycle, which the access edge then clears
      IDX_IRQ_STAT: rbyte = {5'h00, r_next.irq_stat};
      IDX_IRQ_MASK: rbyte = {5'h00, r_next.irq_mask};
      default:      rbyte = 8'h00;
    endcase

    r_next.pready = setup;
    if (setup) begin
      r_next.pslverr = !is_mapped(idx);
      r_next.prdata  = pwrite ? 32'h00000000 : {24'h000000, rbyte};
    end else if (!psel) begin
      r_next.pslverr = 1'b0;
    end
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg            <= '0;
      r_reg.floor_code <= FLOOR_RST;
      r_reg.ceil_code  <= CEIL_RST;
      r_reg.resp       <= RESP_RST;
      r_reg.irq_mask   <= MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata  = r_reg.prdata;
  assign pready  = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq     = r_reg.irq;

endmodule // csnap_top

/* File: verification/csnap_sensor_model.sv */
// Sensor tank model: square wave while running, held low while stopped.
module csnap_sensor_model #(
  parameter int HALF_NS = 200
) (
  input  wire logic run,
  output logic      osc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    osc = 1'b0;
    forever begin
      #(HALF_NS);
      osc <= run ? !osc : 1'b0;
    end
  end
endmodule // csnap_sensor_model

/* File: verification/csnap_top_assertions.sv */
// Port checker for csnap_top: handshake, error answers and snapshot hold.
module csnap_top_assertions
  import csnap_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [5:0] idx;
  logic       ok_idx, rd_acc, fl_wr_reg, dirty_reg, seen_reg;
  logic [7:0] hi_reg;
  assign idx    = paddr[7:2];
  assign ok_idx = idx inside {IDX_CEIL, IDX_FLOOR, IDX_CFG, IDX_PWR, [IDX_STATUS:IDX_FREQ_HI], IDX_IRQ_STAT, IDX_IRQ_MASK};
  assign rd_acc = psel && penable && pready && !pwrite;
  // Any low-byte read may reload, so hold is claimed only between plain high-byte reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_wr_reg <= 1'b0;
      dirty_reg <= 1'b0;
      seen_reg  <= 1'b0;
      hi_reg    <= 8'h00;
    end else if (psel && penable && pready) begin
      if (pwrite && idx == IDX_FLOOR) fl_wr_reg <= 1'b1;
      if (rd_acc && idx == IDX_PROX_LO) dirty_reg <= 1'b1;
      if (rd_acc && idx == IDX_PROX_HI) begin
        dirty_reg <= 1'b0;
        seen_reg  <= 1'b1;
        hi_reg    <= prdata[7:0];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [5:0] i);
    s_setup ##0 (!pwrite && idx == i);
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long answer");
  a_idle_quiet: assert property (!psel |=> !pready) else $error("stray answer");
  a_unmapped_err: assert property (s_setup ##0 !ok_idx |=> pslverr && prdata == 32'h0) else $error("no error");
  a_mapped_ok: assert property (s_setup ##0 ok_idx |=> !pslverr) else $error("false error");
  a_byte_wide: assert property (rd_acc |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_floor_reset: assert property (s_read(IDX_FLOOR) ##0 !fl_wr_reg |=> prdata[7:0] == FLOOR_RST) else $error("floor");
  a_snap_hold: assert property (s_read(IDX_PROX_HI) ##0 (seen_reg && !dirty_reg) |=> prdata[7:0] == hi_reg)
    else $error("snapshot moved");
endmodule // csnap_top_assertions

bind csnap_top csnap_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: verification/testbench.sv */
// Self-checking bench: APB host sequences against csnap_top with a sensor model.
module testbench
  import csnap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0]  resp;
    logic [15:0] rp;
    logic [15:0] prox;
  } csnap_row_s;
  // Floor 0x10 and ceiling 0x80 bound the window to 0x1000..0x8000
  csnap_row_s  rows [3] = '{'{3'h0, 16'h4321, 16'h4321}, '{3'h1, 16'h9000, 16'h8000}, '{3'h0, 16'h0800, 16'h1000}};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic        pready, pslverr, irq, osc_in, rerr;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] rp_level = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [23:0] fx;
  int          fails = 0, n_compared = 0;
  csnap_top u_csnap_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
    .rp_level(rp_level), .irq(irq));
  // Sensor period of 8 clocks, switching on falling clock edges only
  csnap_sensor_model u_csnap_sensor_model (.run(run), .osc(osc_in));
  initial forever #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h1);
  endtask
  // Low-byte read takes any pending result, then status is polled until a fresh one lands
  task automatic next_conv();
    int n;
    n = 0;
    bus(1'b0, IDX_PROX_LO, 32'h0);
    do begin
      bus(1'b0, IDX_STATUS, 32'h0);
      n++;
    end while (rdat[STAT_DRDY_BIT] !== 1'b0 && n < 600);
    chk({31'h0, rdat[STAT_DRDY_BIT]}, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("[FAIL] %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, IDX_FLOOR, 32'h0);
    chk(rdat, 32'h14);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({31'h0, rdat[STAT_DRDY_BIT]}, 32'h1);
    bus(1'b0, 6'h3f, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    $display("test done: reset and unmapped");
    bus(1'b1, IDX_CEIL, 32'h80);
    bus(1'b1, IDX_FLOOR, 32'h10);
    bus(1'b1, IDX_IRQ_MASK, 32'h1);
    bus(1'b1, IDX_PWR, 32'h1);
    run <= 1'b1;
    foreach (rows[k]) begin
      rp_level <= rows[k].rp;
      bus(1'b1, IDX_CFG, {29'h0, rows[k].resp});
      next_conv();
      next_conv();
      fx = 24'(((192 / 3) << rows[k].resp) * 8);
      bus(1'b0, IDX_PROX_LO, 32'h0);
      chk(rdat, {24'h0, rows[k].prox[7:0]});
      bus(1'b0, IDX_PROX_HI, 32'h0);
      chk(rdat, {24'h0, rows[k].prox[15:8]});
      for (int b = 0; b < 3; b++) begin
        bus(1'b0, 6'(IDX_FREQ_LO + b), 32'h0);
        chk(rdat, {24'h0, fx[8*b +: 8]});
      end
      chk({31'h0, irq}, 32'h1);
    end
    $display("test done: table rows");
    rp_level <= 16'h5555;
    repeat (1200) @(posedge pclk);
    bus(1'b0, IDX_PROX_HI, 32'h0);
    chk(rdat, 32'h10);
    bus(1'b1, IDX_FREQ_MID, 32'hff);
    bus(1'b0, IDX_FREQ_MID, 32'h0);
    chk(rdat, 32'h02);
    bus(1'b0, IDX_PROX_LO, 32'h0);
    chk(rdat, 32'h55);
    $display("test done: snapshot hold");
    bus(1'b1, IDX_IRQ_MASK, 32'h0);
    bus(1'b0, IDX_IRQ_STAT, 32'h0);
    next_conv();
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, IDX_IRQ_MASK, 32'h1);
    next_conv();
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, IDX_IRQ_STAT, 32'h0);
    chk({31'h0, rdat[IRQ_NEW_BIT]}, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test done: interrupt");
    run <= 1'b0;
    repeat (260) @(posedge pclk);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({31'h0, rdat[STAT_OSC_BIT]}, 32'h1);
    $display("test done: oscillator stopped");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, IDX_FLOOR, 32'h0);
    chk(rdat, {24'h0, FLOOR_RST});
    bus(1'b0, IDX_PROX_LO, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({31'h0, rdat[STAT_DRDY_BIT]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test done: reset in mid-run");
    tally_and_finish();
  end
endmodule // testbench
